/* logic/mbw_handler.sv */
// Contract
// - single write: address, number, data, check
// - single write answer echoes whole query
// - loopback answer echoes whole query unchanged
// - multi write: start, quantity, count, words
// - quantity outside 1..123 gives code 3
// - byte count must equal twice quantity
// - data words travel high byte first
// - only read/write registers take writes
// - sixteen-bit raw values, range checked outside
// - values are scaled integers, no decimal point
// - address beyond range gives exception
// - unused item reads its default value
// - unused item writes dropped without error
// - multi write stops at faulty register
// - absent items read zero, ignore writes
// - exception: address, code plus 80H, error, check
// - codes 1 function, 2 address, 3 count, 4 diag
// - multi answer: header fields, fresh check
`timescale 1ns/1ps
`default_nettype none
`include "mbw_params.svh"

module mbw_handler (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_end,
  input  wire logic                  diag_fault,
  output logic                       tx_valid,
  output logic      [7:0]            tx_data,
  output logic                       tx_last,
  input  wire logic                  tx_ready,
  output logic      [15:0]           reg_addr,
  output logic      [15:0]           reg_wr_data,
  output logic                       reg_wr_en,
  input  wire mbw_pkg::mbw_attr_type reg_attr,
  input  wire logic                  reg_range_ok,
  input  wire mbw_pkg::mbw_attr_type rd_attr,
  input  wire logic [15:0]           rd_raw,
  input  wire logic [15:0]           rd_default,
  output logic      [15:0]           rd_value
);

  logic [7:0]             buf_q [0:255];
  logic [8:0]             rx_cnt_q;
  logic                   rx_ovf_q;
  mbw_pkg::mbw_state_type state_q;
  mbw_pkg::mbw_resp_type  kind_q;
  logic [7:0]             code_q;
  logic [7:0]             wcnt_q;
  logic [7:0]             wtot_q;
  logic [7:0]             dofs_q;
  logic [8:0]             ti_q;
  logic [8:0]             tn_q;
  logic [7:0]             tx_data_q;
  logic                   tx_valid_q;
  logic                   tx_last_q;
  logic [15:0]            reg_addr_q;
  logic [15:0]            reg_wr_data_q;
  logic                   reg_wr_en_q;
  logic [15:0]            rd_value_q;

  // decoded header fields
  wire [7:0]  fc_w    = buf_q[`MBW_OFS_FC];
  wire [15:0] addr_w  = {buf_q[`MBW_OFS_ADDR_HI], buf_q[`MBW_OFS_ADDR_LO]};
  wire [15:0] qty_w   = {buf_q[`MBW_OFS_QTY_HI], buf_q[`MBW_OFS_QTY_LO]};
  wire [7:0]  bcnt_w  = buf_q[`MBW_OFS_BCNT];
  wire        is_one_w  = (fc_w == `MBW_FC_WR_SINGLE);
  wire        is_loop_w = (fc_w == `MBW_FC_LOOPBACK);
  wire        is_many_w = (fc_w == `MBW_FC_WR_MULTI);
  wire        fc_ok_w   = is_one_w || is_loop_w || is_many_w;
  wire        len_ok_w  = is_many_w ? (rx_cnt_q == (`MBW_LEN_MULTI_HDR + {1'b0, bcnt_w}))
                                    : (rx_cnt_q == `MBW_LEN_FIXED);
  wire        qty_ok_w  = (qty_w >= `MBW_QTY_MIN) && (qty_w <= `MBW_QTY_MAX);
  wire        bcnt_ok_w = ({8'h00, bcnt_w} == {qty_w[14:0], 1'b0});
  wire        test_ok_w = (addr_w == `MBW_TEST_CODE_OK);

  // self-test failure answers every query, then function, then framing and counts
  wire [7:0]  chk_code_w = diag_fault                     ? `MBW_EXC_DIAG  :
                           !fc_ok_w                       ? `MBW_EXC_FUNC  :
                           (rx_ovf_q || !len_ok_w)        ? `MBW_EXC_COUNT :
                           (is_loop_w && !test_ok_w)      ? `MBW_EXC_COUNT :
                           (is_many_w && !qty_ok_w)       ? `MBW_EXC_COUNT :
                           (is_many_w && !bcnt_ok_w)      ? `MBW_EXC_COUNT :
                           `MBW_EXC_NONE;

  // current data word, upper byte first; raw integer, no scaling applied here
  wire [7:0]  wi_w   = dofs_q + {wcnt_q[6:0], 1'b0};
  wire [7:0]  wi1_w  = wi_w + 8'h01;
  wire [15:0] word_w = {buf_q[wi_w], buf_q[wi1_w]};
  wire        wlast_w = ((wcnt_q + 8'h01) == wtot_q);

  wire        do_write_w;
  wire        err_addr_w;
  wire        err_range_w;
  wire [15:0] rd_val_w;

  mbw_reg_gate u_gate (
    .wr_attr     (reg_attr),
    .wr_range_ok (reg_range_ok),
    .rd_attr     (rd_attr),
    .rd_raw      (rd_raw),
    .rd_default  (rd_default),
    .do_write    (do_write_w),
    .err_addr    (err_addr_w),
    .err_range   (err_range_w),
    .rd_value    (rd_val_w)
  );

  // check word is rebuilt only over bytes the handler itself composes
  wire [15:0] crc_w;
  wire [8:0]  crc_body_w = (kind_q == mbw_pkg::RK_SHORT) ? `MBW_BODY_SHORT :
                           (kind_q == mbw_pkg::RK_EXC)   ? `MBW_BODY_EXC   : 9'h000;
  wire        crc_init_w = (state_q == mbw_pkg::ST_CHECK) || (state_q == mbw_pkg::ST_EVAL);
  wire        crc_step_w = (state_q == mbw_pkg::ST_SEND) && tx_ready && (ti_q < crc_body_w);

  mbw_crc16 u_crc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .init    (crc_init_w),
    .step    (crc_step_w),
    .byte_in (tx_data_q),
    .crc     (crc_w)
  );

  // answer byte for position ti_q; check word goes low byte first
  wire [7:0]  echo_byte_w  = buf_q[ti_q[7:0]];
  wire [7:0]  short_byte_w = (ti_q < `MBW_BODY_SHORT) ? buf_q[ti_q[7:0]] :
                             (ti_q == `MBW_BODY_SHORT) ? crc_w[7:0] : crc_w[15:8];
  wire [7:0]  exc_byte_w   = (ti_q == 9'h000) ? buf_q[`MBW_OFS_SLAVE] :
                             (ti_q == 9'h001) ? (fc_w | `MBW_EXC_FLAG) :
                             (ti_q == 9'h002) ? code_q :
                             (ti_q == 9'h003) ? crc_w[7:0] : crc_w[15:8];
  wire [7:0]  byte_sel_w   = (kind_q == mbw_pkg::RK_ECHO)  ? echo_byte_w :
                             (kind_q == mbw_pkg::RK_SHORT) ? short_byte_w : exc_byte_w;

  wire        rx_take_w = (state_q == mbw_pkg::ST_IDLE) && rx_valid && !rx_cnt_q[8];

  // frame store: data only, never read before written
  always_ff @(posedge sys_clk) begin
    if (rx_take_w) begin
      buf_q[rx_cnt_q[7:0]] <= rx_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q       <= mbw_pkg::ST_IDLE;
      kind_q        <= mbw_pkg::RK_ECHO;
      code_q        <= `MBW_EXC_NONE;
      rx_cnt_q      <= 9'h000;
      rx_ovf_q      <= 1'b0;
      wcnt_q        <= 8'h00;
      wtot_q        <= 8'h00;
      dofs_q        <= 8'h00;
      ti_q          <= 9'h000;
      tn_q          <= 9'h000;
      tx_data_q     <= 8'h00;
      tx_valid_q    <= 1'b0;
      tx_last_q     <= 1'b0;
      reg_addr_q    <= 16'h0000;
      reg_wr_data_q <= 16'h0000;
      reg_wr_en_q   <= 1'b0;
    end else begin
      reg_wr_en_q <= 1'b0;
      case (state_q)
        mbw_pkg::ST_IDLE: begin
          // queries arriving while an answer is pending are dropped; the master spaces them
          if (rx_take_w) begin
            rx_cnt_q <= rx_cnt_q + 9'h001;
          end else if (rx_valid) begin
            rx_ovf_q <= 1'b1;
          end
          if (rx_end) begin
            state_q <= mbw_pkg::ST_CHECK;
          end
        end
        mbw_pkg::ST_CHECK: begin
          ti_q <= 9'h000;
          if (chk_code_w != `MBW_EXC_NONE) begin
            kind_q  <= mbw_pkg::RK_EXC;
            code_q  <= chk_code_w;
            tn_q    <= `MBW_LEN_EXC;
            state_q <= mbw_pkg::ST_LOAD;
          end else if (is_loop_w) begin
            kind_q  <= mbw_pkg::RK_ECHO;
            tn_q    <= rx_cnt_q;
            state_q <= mbw_pkg::ST_LOAD;
          end else begin
            wcnt_q  <= 8'h00;
            wtot_q  <= is_one_w ? 8'h01 : qty_w[7:0];
            dofs_q  <= is_one_w ? `MBW_OFS_DATA_ONE : `MBW_OFS_DATA_MANY;
            state_q <= mbw_pkg::ST_FETCH;
          end
        end
        mbw_pkg::ST_FETCH: begin
          reg_addr_q    <= addr_w + {8'h00, wcnt_q};
          reg_wr_data_q <= word_w;
          state_q       <= mbw_pkg::ST_EVAL;
        end
        mbw_pkg::ST_EVAL: begin
          ti_q <= 9'h000;
          if (err_addr_w || err_range_w) begin
            // earlier words stay written, this one and the rest are skipped
            kind_q  <= mbw_pkg::RK_EXC;
            code_q  <= err_addr_w ? `MBW_EXC_ADDR : `MBW_EXC_COUNT;
            tn_q    <= `MBW_LEN_EXC;
            state_q <= mbw_pkg::ST_LOAD;
          end else begin
            reg_wr_en_q <= do_write_w;
            wcnt_q      <= wcnt_q + 8'h01;
            if (wlast_w) begin
              kind_q  <= is_one_w ? mbw_pkg::RK_ECHO : mbw_pkg::RK_SHORT;
              tn_q    <= is_one_w ? rx_cnt_q : `MBW_LEN_SHORT;
              state_q <= mbw_pkg::ST_LOAD;
            end else begin
              state_q <= mbw_pkg::ST_FETCH;
            end
          end
        end
        mbw_pkg::ST_LOAD: begin
          tx_data_q  <= byte_sel_w;
          tx_valid_q <= 1'b1;
          tx_last_q  <= (ti_q == (tn_q - 9'h001));
          state_q    <= mbw_pkg::ST_SEND;
        end
        mbw_pkg::ST_SEND: begin
          if (tx_ready) begin
            tx_valid_q <= 1'b0;
            ti_q       <= ti_q + 9'h001;
            if (tx_last_q) begin
              rx_cnt_q <= 9'h000;
              rx_ovf_q <= 1'b0;
              state_q  <= mbw_pkg::ST_IDLE;
            end else begin
              state_q  <= mbw_pkg::ST_LOAD;
            end
          end
        end
        default: begin
          state_q <= mbw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_value_q <= 16'h0000;
    end else begin
      rd_value_q <= rd_val_w;
    end
  end

  assign tx_valid    = tx_valid_q;
  assign tx_data     = tx_data_q;
  assign tx_last     = tx_last_q;
  assign reg_addr    = reg_addr_q;
  assign reg_wr_data = reg_wr_data_q;
  assign reg_wr_en   = reg_wr_en_q;
  assign rd_value    = rd_value_q;

  a_exc_fc_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_valid && kind_q == mbw_pkg::RK_EXC && ti_q == 9'h001) |-> (tx_data == (fc_w | 8'h80)))
    else $error("exception function code lacks top bit");

  a_qty_range: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_CHECK && !diag_fault && is_many_w && !rx_ovf_q && len_ok_w &&
     (qty_w == 16'h0000 || qty_w > 16'h007B)) |=> (kind_q == mbw_pkg::RK_EXC && code_q == 8'h03))
    else $error("bad quantity not answered with code 3");

  a_bcnt_match: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_CHECK && !diag_fault && is_many_w && !rx_ovf_q && len_ok_w &&
     !bcnt_ok_w) |=> (code_q == 8'h03 && state_q == mbw_pkg::ST_LOAD))
    else $error("byte count mismatch not refused");

  a_diag_first: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_CHECK && diag_fault) |=> (code_q == 8'h04 && kind_q == mbw_pkg::RK_EXC))
    else $error("self-test fault not answered with code 4");

  a_test_code: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_CHECK && !diag_fault && is_loop_w && len_ok_w && !rx_ovf_q &&
     addr_w != 16'h0000) |=> (kind_q == mbw_pkg::RK_EXC))
    else $error("nonzero test code was echoed");

  a_write_rw_only: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr_en |-> ($past(reg_attr) == mbw_pkg::AT_RW && $past(reg_range_ok)))
    else $error("write issued to a non read/write item");

  a_stop_on_err: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_EVAL && (err_addr_w || err_range_w)) |=>
      (!reg_wr_en && state_q == mbw_pkg::ST_LOAD) ##1 (!reg_wr_en && state_q == mbw_pkg::ST_SEND))
    else $error("write continued past a faulty register");

  a_short_len: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_valid && tx_last && kind_q == mbw_pkg::RK_SHORT) |-> (ti_q == 9'h007))
    else $error("multi write answer is not eight bytes");

  a_echo_len: assert property (@(posedge sys_clk) disable iff (rst)
    (tx_valid && tx_last && kind_q == mbw_pkg::RK_ECHO) |-> (ti_q == rx_cnt_q - 9'h001))
    else $error("echo length differs from query");

  a_unsup_fc: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_CHECK && !diag_fault && !fc_ok_w) |=> (code_q == 8'h01))
    else $error("unsupported function not answered with code 1");

  a_addr_err: assert property (@(posedge sys_clk) disable iff (rst)
    (state_q == mbw_pkg::ST_EVAL && reg_attr == mbw_pkg::AT_NONE) |=> (code_q == 8'h02) ##1 tx_valid)
    else $error("address beyond range not refused");

endmodule

`default_nettype wire

/* logic/mbw_params.svh */
`ifndef MBW_PARAMS_SVH
`define MBW_PARAMS_SVH

// function codes served by the handler
`define MBW_FC_WR_SINGLE  8'h06
`define MBW_FC_LOOPBACK   8'h08
`define MBW_FC_WR_MULTI   8'h10

// exception answer
`define MBW_EXC_FLAG      8'h80
`define MBW_EXC_NONE      8'h00
`define MBW_EXC_FUNC      8'h01
`define MBW_EXC_ADDR      8'h02
`define MBW_EXC_COUNT     8'h03
`define MBW_EXC_DIAG      8'h04

// field limits
`define MBW_QTY_MIN       16'h0001
`define MBW_QTY_MAX       16'h007B
`define MBW_TEST_CODE_OK  16'h0000

// byte positions inside a received frame
`define MBW_OFS_SLAVE     8'h00
`define MBW_OFS_FC        8'h01
`define MBW_OFS_ADDR_HI   8'h02
`define MBW_OFS_ADDR_LO   8'h03
`define MBW_OFS_QTY_HI    8'h04
`define MBW_OFS_QTY_LO    8'h05
`define MBW_OFS_BCNT      8'h06
`define MBW_OFS_DATA_ONE  8'h04
`define MBW_OFS_DATA_MANY 8'h07

// frame and answer lengths in bytes
`define MBW_LEN_FIXED     9'h008
`define MBW_LEN_MULTI_HDR 9'h009
`define MBW_LEN_SHORT     9'h008
`define MBW_BODY_SHORT    9'h006
`define MBW_LEN_EXC       9'h005
`define MBW_BODY_EXC      9'h003
`define MBW_BUF_FULL      9'h100

// check word
`define MBW_CRC_INIT      16'hFFFF
`define MBW_CRC_POLY      16'hA001

`endif

/* logic/mbw_pkg.sv */
`default_nettype none

package mbw_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_FETCH = 3'b010,
    ST_EVAL  = 3'b011,
    ST_LOAD  = 3'b100,
    ST_SEND  = 3'b101
  } mbw_state_type;

  typedef enum logic [1:0] {
    RK_ECHO  = 2'b00,
    RK_SHORT = 2'b01,
    RK_EXC   = 2'b10
  } mbw_resp_type;

  typedef enum logic [2:0] {
    AT_NONE   = 3'b000,
    AT_UNUSED = 3'b001,
    AT_ABSENT = 3'b010,
    AT_RO     = 3'b011,
    AT_RW     = 3'b100
  } mbw_attr_type;

endpackage

`default_nettype wire

/* logic/mbw_crc16.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbw_params.svh"

module mbw_crc16 (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        init,
  input  wire logic        step,
  input  wire logic [7:0]  byte_in,
  output logic      [15:0] crc
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // one whole byte per cycle, lsb first, so the answer never stalls on the check word
  always_comb begin
    crc_d = crc_q ^ {8'h00, byte_in};
    for (int i = 0; i < 8; i++) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ `MBW_CRC_POLY) : (crc_d >> 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || init) begin
      crc_q <= `MBW_CRC_INIT;
    end else if (step) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule

`default_nettype wire

/* logic/mbw_reg_gate.sv */
`timescale 1ns/1ps
`default_nettype none

module mbw_reg_gate (
  input  wire mbw_pkg::mbw_attr_type wr_attr,
  input  wire logic                  wr_range_ok,
  input  wire mbw_pkg::mbw_attr_type rd_attr,
  input  wire logic [15:0]           rd_raw,
  input  wire logic [15:0]           rd_default,
  output logic                       do_write,
  output logic                       err_addr,
  output logic                       err_range,
  output logic      [15:0]           rd_value
);

  assign err_addr  = (wr_attr == mbw_pkg::AT_NONE);
  assign do_write  = (wr_attr == mbw_pkg::AT_RW) && wr_range_ok;
  assign err_range = (wr_attr == mbw_pkg::AT_RW) && !wr_range_ok;
  // unused, absent and read-only items fall through silently

  assign rd_value = (rd_attr == mbw_pkg::AT_UNUSED) ? rd_default :
                    ((rd_attr == mbw_pkg::AT_ABSENT) ||
                     (rd_attr == mbw_pkg::AT_NONE)) ? 16'h0000 :
                    rd_raw;

endmodule

`default_nettype wire

/* tb/mbw_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module mbw_master_model (
  input  wire logic       sys_clk,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_end,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] txq[$];
  logic [7:0] ans[$];
  int         last_cnt = 0;
  logic [1:0] stall_q  = 2'h0;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_end   = 1'b0;
    tx_ready = 1'b0;
  end

  // slow mode takes one byte in three so every answer byte has to wait
  always @(posedge sys_clk) begin
    stall_q  <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
    tx_ready <= slow ? (stall_q == 2'h0) : 1'b1;
    if (tx_valid && tx_ready) begin
      ans.push_back(tx_data);
      if (tx_last)
        last_cnt <= last_cnt + 1;
    end
  end

  // query bytes back to back, end mark with the last one
  task automatic exchange();
    int start;
    int n;
    start = last_cnt;
    n = 0;
    ans.delete();
    foreach (txq[i]) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_data  <= txq[i];
      rx_end   <= (i == txq.size() - 1);
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_end   <= 1'b0;
    rx_data  <= ~rx_data;
    while (last_cnt == start && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    // quiet gap of at least 24 bit times before the next query
    repeat (30) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbw_params.svh"

module testbench;
  logic                  sys_clk;
  logic                  rst;
  logic                  slow;
  logic                  diag_fault;
  logic                  rx_valid;
  logic [7:0]            rx_data;
  logic                  rx_end;
  logic                  tx_valid;
  logic [7:0]            tx_data;
  logic                  tx_last;
  logic                  tx_ready;
  logic [15:0]           reg_addr;
  logic [15:0]           reg_wr_data;
  logic                  reg_wr_en;
  mbw_pkg::mbw_attr_type reg_attr;
  logic                  reg_range_ok;
  mbw_pkg::mbw_attr_type rd_attr;
  logic [15:0]           rd_raw;
  logic [15:0]           rd_default;
  logic [15:0]           rd_value;
  logic [7:0]            frm[$];
  logic [7:0]            exp[$];
  logic [31:0]           wlog[$];
  int                    miscompares = 0;
  int                    total_checks = 0;

  // small map: a few special items, everything from 4000H up is outside the range
  assign reg_attr = (reg_addr >= 16'h4000) ? mbw_pkg::AT_NONE :
                    (reg_addr == 16'h0100) ? mbw_pkg::AT_UNUSED :
                    (reg_addr == 16'h0200) ? mbw_pkg::AT_ABSENT :
                    (reg_addr == 16'h0300) ? mbw_pkg::AT_RO : mbw_pkg::AT_RW;
  assign reg_range_ok = ($signed(reg_wr_data) >= $signed(16'hFF38)) &&
                        ($signed(reg_wr_data) <= $signed(16'h03E8));

  mbw_handler dut (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .diag_fault(diag_fault), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_attr(reg_attr), .reg_range_ok(reg_range_ok),
    .rd_attr(rd_attr), .rd_raw(rd_raw), .rd_default(rd_default), .rd_value(rd_value));

  mbw_master_model mm (.sys_clk(sys_clk), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (reg_wr_en)
      wlog.push_back({reg_addr, reg_wr_data});
  end

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] want, input string what);
    total_checks++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic check_frame();
    logic ok;
    ok = (mm.ans.size() == exp.size());
    foreach (exp[i])
      if (ok && mm.ans[i] !== exp[i])
        ok = 1'b0;
    check_val({31'h0, ok}, 32'h1, "answer frame");
  endtask

  function automatic logic [15:0] crc_q(ref logic [7:0] d[$]);
    logic [15:0] c;
    c = `MBW_CRC_INIT;
    foreach (d[i]) begin
      c = c ^ {8'h00, d[i]};
      repeat (8)
        c = c[0] ? ((c >> 1) ^ `MBW_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // check word goes low byte first
  task automatic seal(ref logic [7:0] d[$]);
    logic [15:0] c;
    c = crc_q(d);
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
  endtask

  task automatic exc(input logic [7:0] fc, input logic [7:0] code);
    exp = {8'h01, fc | `MBW_EXC_FLAG, code};
    seal(exp);
  endtask

  task automatic run(input logic echo);
    seal(frm);
    if (echo)
      exp = frm;
    wlog.delete();
    mm.txq = frm;
    mm.exchange();
    check_frame();
  endtask

  task automatic t_single();
    frm = {8'h01, `MBW_FC_WR_SINGLE, 8'h0A, 8'hDC, 8'h00, 8'h64};
    run(1'b1);
    check_val(wlog.size(), 32'h1, "single write count");
    check_val(wlog[0], 32'h0ADC0064, "single write word");
  endtask

  task automatic t_ignored();
    logic [7:0] hi[3];
    hi = '{8'h01, 8'h02, 8'h03};
    for (int i = 0; i < 3; i++) begin
      frm = {8'h01, `MBW_FC_WR_SINGLE, hi[i], 8'h00, 8'h12, 8'h34};
      run(1'b1);
      check_val(wlog.size(), 32'h0, "ignored write");
    end
    frm = {8'h01, `MBW_FC_WR_SINGLE, 8'h40, 8'h00, 8'h00, 8'h01};
    exc(`MBW_FC_WR_SINGLE, `MBW_EXC_ADDR);
    run(1'b0);
  endtask

  task automatic t_loop();
    slow <= 1'b1;
    // test code kept at zero for the good query
    frm = {8'h01, `MBW_FC_LOOPBACK, 8'h00, 8'h00, 8'h1F, 8'h34};
    run(1'b1);
    frm = {8'h01, `MBW_FC_LOOPBACK, 8'h00, 8'h01, 8'h1F, 8'h34};
    exc(`MBW_FC_LOOPBACK, `MBW_EXC_COUNT);
    run(1'b0);
    slow <= 1'b0;
  endtask

  task automatic t_multi();
    // FF38H is a negative word in two's complement, still inside the map's range
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h0A, 8'hDC, 8'h00, 8'h02, 8'h04,
           8'h00, 8'h64, 8'hFF, 8'h38};
    exp = frm[0:5];
    seal(exp);
    run(1'b0);
    check_val(wlog.size(), 32'h2, "multi count");
    check_val(wlog[1], 32'h0ADDFF38, "multi second word");
  endtask

  task automatic t_abort();
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h0A, 8'hDC, 8'h00, 8'h03, 8'h06,
           8'h00, 8'h64, 8'h7F, 8'hFF, 8'h00, 8'h01};
    exc(`MBW_FC_WR_MULTI, `MBW_EXC_COUNT);
    run(1'b0);
    check_val(wlog.size(), 32'h1, "range abort count");
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h3F, 8'hFF, 8'h00, 8'h02, 8'h04,
           8'h00, 8'h11, 8'h00, 8'h22};
    exc(`MBW_FC_WR_MULTI, `MBW_EXC_ADDR);
    run(1'b0);
    check_val(wlog.size(), 32'h1, "address abort count");
    check_val(wlog[0], 32'h3FFF0011, "address abort word");
  endtask

  task automatic t_qty();
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h0A, 8'hDC, 8'h00, 8'h00, 8'h00};
    exc(`MBW_FC_WR_MULTI, `MBW_EXC_COUNT);
    run(1'b0);
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h0A, 8'hDC, 8'h00, 8'h7C, 8'h02, 8'h00, 8'h01};
    run(1'b0);
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h0A, 8'hDC, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02};
    run(1'b0);
    frm = {8'h01, `MBW_FC_WR_MULTI, 8'h0A, 8'hDC, 8'h00, 8'h7B, 8'hF6};
    for (int i = 0; i < 123; i++) begin
      frm.push_back(8'h00);
      frm.push_back(i[7:0]);
    end
    exp = frm[0:5];
    seal(exp);
    run(1'b0);
    check_val(wlog.size(), 32'h7B, "max quantity count");
    check_val(wlog[122], 32'h0B56007A, "max quantity last word");
  endtask

  task automatic t_faults();
    frm = {8'h01, 8'h05, 8'h00, 8'h01, 8'hFF, 8'h00};
    exc(8'h05, `MBW_EXC_FUNC);
    run(1'b0);
    // one byte short of a single write frame is refused with code 3
    frm = {8'h01, `MBW_FC_WR_SINGLE, 8'h0A, 8'hDC, 8'h00};
    exc(`MBW_FC_WR_SINGLE, `MBW_EXC_COUNT);
    run(1'b0);
    check_val(wlog.size(), 32'h0, "no write on short frame");
    // more bytes than the frame store holds overflows and is refused
    frm = {8'h01, `MBW_FC_WR_MULTI};
    for (int i = 0; i < 255; i++) begin
      frm.push_back(8'h00);
    end
    exc(`MBW_FC_WR_MULTI, `MBW_EXC_COUNT);
    run(1'b0);
    check_val(wlog.size(), 32'h0, "no write on overflow");
    diag_fault <= 1'b1;
    frm = {8'h01, `MBW_FC_WR_SINGLE, 8'h0A, 8'hDC, 8'h00, 8'h64};
    exc(`MBW_FC_WR_SINGLE, `MBW_EXC_DIAG);
    run(1'b0);
    check_val(wlog.size(), 32'h0, "no write on fault");
    diag_fault <= 1'b0;
  endtask

  task automatic t_read();
    mbw_pkg::mbw_attr_type at[5];
    logic [15:0]           want[5];
    at = '{mbw_pkg::AT_UNUSED, mbw_pkg::AT_ABSENT, mbw_pkg::AT_NONE, mbw_pkg::AT_RO,
           mbw_pkg::AT_RW};
    want = '{16'h1234, 16'h0000, 16'h0000, 16'hABCD, 16'hABCD};
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      rd_attr    <= at[i];
      rd_raw     <= 16'hABCD;
      rd_default <= 16'h1234;
      repeat (2) @(posedge sys_clk);
      #1 check_val(rd_value, want[i], "read value");
    end
  endtask

  initial begin
    rst        = 1'b1;
    slow       = 1'b0;
    diag_fault = 1'b0;
    rd_attr    = mbw_pkg::AT_NONE;
    rd_raw     = 16'h0000;
    rd_default = 16'h0000;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 check_val({tx_valid, reg_wr_en, rd_value}, 32'h0, "idle after reset");
    t_single();
    t_ignored();
    t_loop();
    t_multi();
    t_abort();
    t_qty();
    t_faults();
    t_read();
    report_and_stop();
  end

  // the whole run needs a few thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end
endmodule

`default_nettype wire
